// File: rtl/flash_seq_consts.vh
// Constants for the flash table access sequencer.
`ifndef FLASH_SEQ_CONSTS_VH
`define FLASH_SEQ_CONSTS_VH
`define ADDR_PTR_LOW 4'h0
`define ADDR_PTR_HIGH 4'h1
`define ADDR_PTR_UPPER 4'h2
`define ADDR_LATCH 4'h3
`define ADDR_CONTROL 4'h4
`define ADDR_UNLOCK 4'h5
`define ADDR_STATUS 4'h6
`define ADDR_OP 4'h7
`define BIT_PSEL 7
`define BIT_CSEL 6
`define BIT_ERASE 4
`define BIT_ABORT 3
`define BIT_ALLOW 2
`define BIT_GO 1
`define BIT_DONE 0
`define UNLOCK_FIRST 8'h55
`define UNLOCK_SECOND 8'hAA
`define OP_NONE 2'h0
`define OP_POSTINC 2'h1
`define OP_POSTDEC 2'h2
`define OP_PREINC 2'h3
`define OP_FETCH_BIT 2
`define OP_LOAD_BIT 3
`define CTRL_RESET 8'h00
`define TIMED_US 2000
`define CLK_MHZ 40
`define TIMED_CYCLES (`TIMED_US * `CLK_MHZ)
`endif

// File: rtl/flash_table_access_sequencer.v
// Flash table access sequencer: pointer, latch, holding registers and timed erase/program.
`timescale 1ns/1ps
`include "flash_seq_consts.vh"

module flash_table_access_sequencer #(
  parameter TIMED_CYCLES = `TIMED_CYCLES
) (
  // Clock and reset.
  input wire CLK_SYS_I,
  input wire RESETN_I,
  // Interrupted-cycle reset cause, from the reset controller on this clock.
  input wire CYCLE_ABORT_I,
  // Register port.
  input wire [3:0] ADDR_I,
  input wire [7:0] WDATA_I,
  input wire WR_I,
  input wire RD_I,
  output reg [7:0] RDATA_O,
  // Flash array port: 16-bit words, word address is pointer bits 21..1.
  output reg [20:0] FLASH_WORD_ADDR_O,
  input wire [15:0] FLASH_RDATA_I,
  output reg FLASH_ERASE_O,
  output reg FLASH_PROG_O,
  output reg [63:0] FLASH_WDATA_O,
  // Core stall.
  output reg STALL_O,
  output reg DONE_FLAG_O
);

  localparam ST_IDLE = 3'b001;
  localparam ST_ERASE = 3'b010;
  localparam ST_PROG = 3'b100;

  reg [21:0] ptr_reg;
  reg [7:0] latch_reg;
  reg [7:0] hold_reg [0:7];
  reg psel_reg;
  reg csel_reg;
  reg erase_en_reg;
  reg allow_reg;
  reg abort_reg;
  reg done_reg;
  reg [1:0] unlock_reg;
  reg [2:0] state_reg;
  reg [31:0] timer_reg;
  reg fetch_pend_reg;
  reg fetch_hi_reg;
  reg [7:0] rdata_next;
  reg [21:0] ptr_next;
  reg [21:0] ptr_access;
  integer i;

  // Steps keep bit 21 so a run of fetches never wanders between spaces.
  function [21:0] step_ptr;
    input [21:0] p;
    input up;
    begin
      step_ptr = {p[21], up ? p[20:0] + 21'h000001 : p[20:0] - 21'h000001};
    end
  endfunction

  // Register port decode; at most one strobe is high in any cycle.
  wire ptr_low_wr = WR_I && (ADDR_I == `ADDR_PTR_LOW);
  wire ptr_high_wr = WR_I && (ADDR_I == `ADDR_PTR_HIGH);
  wire ptr_upper_wr = WR_I && (ADDR_I == `ADDR_PTR_UPPER);
  wire latch_wr = WR_I && (ADDR_I == `ADDR_LATCH);
  wire ctrl_wr = WR_I && (ADDR_I == `ADDR_CONTROL);
  wire unlock_wr = WR_I && (ADDR_I == `ADDR_UNLOCK);
  wire status_wr = WR_I && (ADDR_I == `ADDR_STATUS);
  wire busy = (state_reg != ST_IDLE);

  // The core is stalled during a timed cycle, so table operations are dropped then.
  wire op_wr = WR_I && (ADDR_I == `ADDR_OP) && !busy;
  wire fetch_op = op_wr && WDATA_I[`OP_FETCH_BIT];
  wire load_op = op_wr && !WDATA_I[`OP_FETCH_BIT] && WDATA_I[`OP_LOAD_BIT];

  // The go write must carry allow and program select itself: the unlock pair has to come
  // right before it and leaves no room for a separate write of those bits.
  wire go_req = ctrl_wr && WDATA_I[`BIT_GO];
  wire go_ok = go_req && (unlock_reg == 2'h2) && WDATA_I[`BIT_ALLOW] && WDATA_I[`BIT_PSEL] &&
               !busy;
  wire erase_go = go_ok && WDATA_I[`BIT_ERASE];
  wire prog_go = go_ok && !WDATA_I[`BIT_ERASE];

  // The timer is loaded with the full count at launch and ends the cycle when it reaches one.
  wire timer_end = busy && (timer_reg == 32'h00000001);
  wire erase_done = timer_end && (state_reg == ST_ERASE);
  wire prog_done = timer_end && (state_reg == ST_PROG);

  reg [21:0] ptr_stepped;
  reg [1:0] unlock_next;
  reg done_next;
  reg [2:0] state_next;
  reg [31:0] timer_next;

  // Pointer stepping for the table operations.
  always @* begin
    ptr_access = ptr_reg;
    ptr_stepped = ptr_reg;
    if (op_wr) begin
      case (WDATA_I[1:0])
        `OP_POSTINC: begin
          ptr_stepped = step_ptr(ptr_reg, 1'b1);
        end
        `OP_POSTDEC: begin
          ptr_stepped = step_ptr(ptr_reg, 1'b0);
        end
        `OP_PREINC: begin
          ptr_access = step_ptr(ptr_reg, 1'b1);
          ptr_stepped = ptr_access;
        end
        default: begin
          ptr_stepped = ptr_reg;
        end
      endcase
    end
  end

  // Byte writes from software replace the matching slice of the pointer.
  always @* begin
    ptr_next = ptr_stepped;
    if (ptr_low_wr) begin
      ptr_next[7:0] = WDATA_I;
    end
    if (ptr_high_wr) begin
      ptr_next[15:8] = WDATA_I;
    end
    if (ptr_upper_wr) begin
      ptr_next[21:16] = WDATA_I[5:0];
    end
  end

  always @(posedge CLK_SYS_I) begin
    if (!RESETN_I) begin
      ptr_reg <= 22'h000000;
    end else begin
      ptr_reg <= ptr_next;
    end
  end

  // Any other write in between drops the sequence, so a stray store cannot arm the go bit.
  always @* begin
    unlock_next = unlock_reg;
    if (unlock_wr && (WDATA_I == `UNLOCK_FIRST)) begin
      unlock_next = 2'h1;
    end else if (unlock_wr && (WDATA_I == `UNLOCK_SECOND) && (unlock_reg == 2'h1)) begin
      unlock_next = 2'h2;
    end else if (WR_I) begin
      unlock_next = 2'h0;
    end
  end

  always @(posedge CLK_SYS_I) begin
    if (!RESETN_I) begin
      unlock_reg <= 2'h0;
    end else begin
      unlock_reg <= unlock_next;
    end
  end

  // The array answers a word address in the same cycle it is presented, and the address is registered, so the byte is
  // picked one cycle after the fetch.
  always @(posedge CLK_SYS_I) begin
    if (!RESETN_I) begin
      latch_reg <= 8'h00;
      fetch_pend_reg <= 1'b0;
      fetch_hi_reg <= 1'b0;
    end else begin
      fetch_pend_reg <= fetch_op;
      if (fetch_op) begin
        fetch_hi_reg <= ptr_access[0];
      end
      if (latch_wr) begin
        latch_reg <= WDATA_I;
      end
      if (fetch_pend_reg) begin
        latch_reg <= fetch_hi_reg ? FLASH_RDATA_I[15:8] : FLASH_RDATA_I[7:0];
      end
    end
  end

  // Holding registers return to the erased level after each block is programmed.
  always @(posedge CLK_SYS_I) begin
    if (!RESETN_I) begin
      for (i = 0; i < 8; i = i + 1) begin
        hold_reg[i] <= 8'hFF;
      end
    end else if (prog_done) begin
      for (i = 0; i < 8; i = i + 1) begin
        hold_reg[i] <= 8'hFF;
      end
    end else if (load_op) begin
      hold_reg[ptr_access[2:0]] <= latch_reg;
    end
  end

  // Selects and the abort flag have no reset value on purpose: they survive a reset so that
  // software can trace an interrupted cycle afterwards.
  always @(posedge CLK_SYS_I) begin
    if (!RESETN_I) begin
      if (busy && CYCLE_ABORT_I) begin
        abort_reg <= 1'b1;
      end
    end else if (ctrl_wr) begin
      psel_reg <= WDATA_I[`BIT_PSEL];
      csel_reg <= WDATA_I[`BIT_CSEL];
      if (!WDATA_I[`BIT_ABORT]) begin
        abort_reg <= 1'b0;
      end
    end
  end

  always @(posedge CLK_SYS_I) begin
    if (!RESETN_I) begin
      erase_en_reg <= 1'b0;
      allow_reg <= 1'b0;
    end else begin
      if (ctrl_wr) begin
        erase_en_reg <= WDATA_I[`BIT_ERASE];
        allow_reg <= WDATA_I[`BIT_ALLOW];
      end
      if (erase_done) begin
        erase_en_reg <= 1'b0;
      end
    end
  end

  // Completion wins over a clear in the same cycle, so a finished cycle is never lost.
  always @* begin
    done_next = done_reg;
    if (status_wr && !WDATA_I[`BIT_DONE]) begin
      done_next = 1'b0;
    end
    if (timer_end) begin
      done_next = 1'b1;
    end
  end

  always @(posedge CLK_SYS_I) begin
    if (!RESETN_I) begin
      done_reg <= 1'b0;
      DONE_FLAG_O <= 1'b0;
    end else begin
      done_reg <= done_next;
      DONE_FLAG_O <= done_next;
    end
  end

  // Sequencer: one timed state per kind of long write.
  always @* begin
    state_next = state_reg;
    timer_next = timer_reg;
    case (state_reg)
      ST_IDLE: begin
        if (erase_go) begin
          state_next = ST_ERASE;
          timer_next = TIMED_CYCLES;
        end else if (prog_go) begin
          state_next = ST_PROG;
          timer_next = TIMED_CYCLES;
        end
      end
      ST_ERASE, ST_PROG: begin
        timer_next = timer_reg - 32'h00000001;
        if (timer_end) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
        timer_next = 32'h00000000;
      end
    endcase
  end

  always @(posedge CLK_SYS_I) begin
    if (!RESETN_I) begin
      state_reg <= ST_IDLE;
      timer_reg <= 32'h00000000;
    end else begin
      state_reg <= state_next;
      timer_reg <= timer_next;
    end
  end

  // The stall follows the next state, so it rises with the start pulse and falls on the
  // edge that returns the sequencer to idle.
  always @(posedge CLK_SYS_I) begin
    if (!RESETN_I) begin
      STALL_O <= 1'b0;
      FLASH_ERASE_O <= 1'b0;
      FLASH_PROG_O <= 1'b0;
    end else begin
      STALL_O <= (state_next != ST_IDLE);
      FLASH_ERASE_O <= erase_go;
      FLASH_PROG_O <= prog_go;
    end
  end

  // One address port serves fetches and long writes; they never meet, as fetches stop while busy.
  always @(posedge CLK_SYS_I) begin
    if (!RESETN_I) begin
      FLASH_WORD_ADDR_O <= 21'h000000;
      FLASH_WDATA_O <= 64'h0000000000000000;
    end else if (fetch_op) begin
      // Bit 21 rides along on the address so the array maps config space.
      FLASH_WORD_ADDR_O <= ptr_access[21:1];
    end else if (erase_go) begin
      FLASH_WORD_ADDR_O <= {ptr_reg[21:6], 5'h00};
    end else if (prog_go) begin
      FLASH_WORD_ADDR_O <= {ptr_reg[21:3], 2'h0};
      FLASH_WDATA_O <= {hold_reg[7], hold_reg[6], hold_reg[5], hold_reg[4],
                        hold_reg[3], hold_reg[2], hold_reg[1], hold_reg[0]};
    end
  end

  always @* begin
    case (ADDR_I)
      `ADDR_PTR_LOW: rdata_next = ptr_reg[7:0];
      `ADDR_PTR_HIGH: rdata_next = ptr_reg[15:8];
      `ADDR_PTR_UPPER: rdata_next = {2'h0, ptr_reg[21:16]};
      `ADDR_LATCH: rdata_next = latch_reg;
      `ADDR_CONTROL: rdata_next = {psel_reg, csel_reg, 1'b0, erase_en_reg, abort_reg, allow_reg,
                                   busy, 1'b0};
      `ADDR_STATUS: rdata_next = {7'h00, done_reg};
      `ADDR_UNLOCK: rdata_next = 8'h00;
      default: rdata_next = 8'h00;
    endcase
  end

  // Read data is zero outside the answer cycle, so idle bus cycles carry no stale value.
  always @(posedge CLK_SYS_I) begin
    if (!RESETN_I) begin
      RDATA_O <= 8'h00;
    end else if (RD_I) begin
      RDATA_O <= rdata_next;
    end else begin
      RDATA_O <= 8'h00;
    end
  end

endmodule

// File: sim/flash_array_model.sv
// Flash array model: each word derived from its word address.
`timescale 1ns/1ps
module flash_array_model (
  input wire [20:0] word_addr_i,
  output wire [15:0] word_o);
  // Both bytes differ and the low byte depends on the top bit, so a lane swap or lost space bit shows.
  assign word_o = {word_addr_i[7:0] ^ 8'h3C, word_addr_i[15:8] ^ word_addr_i[20:13]};
endmodule

// File: sim/flash_seq_assertions.sv
// Checker on the sequencer's top-level ports.
`timescale 1ns/1ps
`include "flash_seq_consts.vh"
module flash_seq_chk #(parameter TIMED_CYCLES = 10) (
  input wire CLK_SYS_I, input wire RESETN_I, input wire WR_I, input wire RD_I,
  input wire [3:0] ADDR_I, input wire [7:0] WDATA_I, input wire [7:0] RDATA_O,
  input wire FLASH_ERASE_O, input wire FLASH_PROG_O, input wire STALL_O, input wire DONE_FLAG_O);
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (!RESETN_I);
  logic [31:0] cnt_reg;
  always @(posedge CLK_SYS_I) cnt_reg <= (!RESETN_I || !STALL_O) ? 32'h0 : cnt_reg + 32'h1;
  sequence unlock_s;
    WR_I && ADDR_I == `ADDR_UNLOCK && WDATA_I == `UNLOCK_FIRST ##1
    WR_I && ADDR_I == `ADDR_UNLOCK && WDATA_I == `UNLOCK_SECOND;
  endsequence
  sequence go_s;
    WR_I && ADDR_I == `ADDR_CONTROL && WDATA_I[`BIT_GO] && WDATA_I[`BIT_ALLOW] && WDATA_I[`BIT_PSEL] && !STALL_O;
  endsequence
  launch_taken_a: assert property (unlock_s ##1 go_s |=> STALL_O) else $error("launch ignored");
  unlock_needed_a: assert property ($rose(STALL_O) |-> $past(WR_I && WDATA_I == `UNLOCK_SECOND, 2))
    else $error("stall without unlock");
  start_pulse_a: assert property ($rose(STALL_O) |-> FLASH_PROG_O ^ FLASH_ERASE_O) else $error("no start");
  single_pulse_a: assert property ($past(STALL_O) |-> !FLASH_PROG_O && !FLASH_ERASE_O) else $error("restart");
  stall_len_a: assert property ($fell(STALL_O) |-> cnt_reg == TIMED_CYCLES) else $error("stall length");
  done_set_a: assert property ($fell(STALL_O) |-> ##[0:1] DONE_FLAG_O) else $error("no done");
  rdata_idle_a: assert property (!$past(RD_I) |-> RDATA_O == 8'h00) else $error("stray read data");
  unlock_zero_a: assert property (RD_I && ADDR_I == `ADDR_UNLOCK |=> RDATA_O == 8'h00) else $error("unlock read");
endmodule

// File: sim/tb_flash_table_access_sequencer.sv
// Testbench for the flash table access sequencer.
`timescale 1ns/1ps
module tb_flash_table_access_sequencer;
  reg clk = 1'h0, rstn = 1'h0, abrt = 1'h0, wr = 1'h0, rd = 1'h0;
  reg [3:0] addr = 4'h0;
  reg [7:0] wd = 8'h00, got, hold [0:7];
  reg [21:0] ptr;
  reg [31:0] lf = 32'hA61B;
  reg [63:0] blk;
  wire [7:0] rdat;
  wire [20:0] fa;
  wire [15:0] fd;
  wire [63:0] fw;
  wire fe, fp, st, dn;
  integer error_cnt = 0, checks_done = 0, cyc = 0, i, m;
  flash_table_access_sequencer #(.TIMED_CYCLES(10)) i_flash_table_access_sequencer (.CLK_SYS_I(clk),
    .RESETN_I(rstn), .CYCLE_ABORT_I(abrt), .ADDR_I(addr), .WDATA_I(wd), .WR_I(wr), .RD_I(rd), .RDATA_O(rdat),
    .FLASH_WORD_ADDR_O(fa), .FLASH_RDATA_I(fd), .FLASH_ERASE_O(fe), .FLASH_PROG_O(fp), .FLASH_WDATA_O(fw),
    .STALL_O(st), .DONE_FLAG_O(dn));
  flash_array_model i_flash_array_model (.word_addr_i(fa), .word_o(fd));
  initial forever #12.5 clk = ~clk;
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 2000) begin
      error_cnt = error_cnt + 1;
      test_done;
    end
  end
  function [7:0] fbyte(input [21:0] p);
    fbyte = p[0] ? p[8:1] ^ 8'h3C : p[16:9] ^ p[21:14];
  endfunction
  function [21:0] stp(input [21:0] p, input up);
    stp = {p[21], up ? p[20:0] + 21'h1 : p[20:0] - 21'h1};
  endfunction
  function [31:0] lfsr(input [31:0] v);
    lfsr = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task chk(input [63:0] s, input [63:0] e);
    begin
      checks_done = checks_done + 1;
      if (s !== e) begin
        error_cnt = error_cnt + 1;
        $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
      end
    end
  endtask
  task w(input [3:0] a, input [7:0] d);
    begin @(posedge clk); wr <= 1'h1; rd <= 1'h0; addr <= a; wd <= d; end
  endtask
  task idle(input integer n);
    repeat (n) begin @(posedge clk); wr <= 1'h0; rd <= 1'h0; end
  endtask
  task r(input [3:0] a);
    begin @(posedge clk); wr <= 1'h0; rd <= 1'h1; addr <= a; @(posedge clk); rd <= 1'h0; #1 got = rdat; end
  endtask
  task setp(input [21:0] p);
    begin ptr = p; w(4'h0, p[7:0]); w(4'h1, p[15:8]); w(4'h2, {2'h0, p[21:16]}); end
  endtask
  task launch(input [7:0] c);
    begin w(4'h5, 8'h55); w(4'h5, 8'hAA); w(4'h4, c); idle(1); #1; end
  endtask
  task timed(input [7:0] c);
    begin
      launch(c);
      chk({st, fp, fe}, {1'h1, ~c[4], c[4]});
      if (c[4]) chk(fa[20:5], ptr[21:6]);
      else chk({fa[20:2], fw}, {ptr[21:3], blk});
      for (i = 0; i < 50 && st === 1'h1; i = i + 1) begin @(posedge clk); #1; end
      chk(i, 32'hA);
      chk(dn, 1'h1);
      r(4'h4);
      chk(got & 8'h12, 8'h00);
      w(4'h6, 8'h00); idle(1); #1;
      chk(dn, 1'h0);
    end
  endtask
  task test_done;
    begin
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
    end
  endtask
  initial begin
    idle(8); @(posedge clk) rstn <= 1'h1;
    // Each mode at the 21-bit wrap, with and without the space-select bit.
    for (i = 0; i < 8; i = i + 1) begin
      m = i % 4;
      setp({i[2], (m == 2) ? 21'h0 : 21'h1FFFFF});
      if (m == 3) ptr = stp(ptr, 1'h1);
      blk[7:0] = fbyte(ptr);
      w(4'h7, 8'h04 | m[7:0]); idle(3);
      if (m == 1 || m == 2) ptr = stp(ptr, m == 1);
      r(4'h3);
      chk(got, blk[7:0]);
      r(4'h0); chk(got, ptr[7:0]);
      r(4'h2); chk(got, {2'h0, ptr[21:16]});
    end
    r(4'h5); chk(got, 8'h00);
    $display("fetch test end");
    // Unaligned start: the post-increments carry the pointer into the next block.
    setp(22'h012345);
    for (i = 0; i < 8; i = i + 1) begin
      lf = lfsr(lf);
      hold[ptr[2:0]] = lf[7:0];
      w(4'h3, lf[7:0]); w(4'h7, 8'h09); ptr = stp(ptr, 1'h1);
    end
    for (i = 0; i < 8; i = i + 1) blk[i*8 +: 8] = hold[i];
    timed(8'h86);
    $display("program test end");
    setp(22'h01237F);
    timed(8'h96);
    $display("erase test end");
    w(4'h5, 8'h55); w(4'h5, 8'hAA); w(4'h3, 8'h00); w(4'h4, 8'h86); idle(2); #1;
    chk(st, 1'h0);
    launch(8'h86);
    @(posedge clk) begin abrt <= 1'h1; rstn <= 1'h0; end
    idle(2); @(posedge clk) begin abrt <= 1'h0; rstn <= 1'h1; end
    r(4'h4); chk(got & 8'hCA, 8'h88);
    $display("abort test end");
    test_done;
  end
endmodule
bind flash_table_access_sequencer flash_seq_chk #(.TIMED_CYCLES(TIMED_CYCLES)) i_flash_seq_chk (
  .CLK_SYS_I(CLK_SYS_I), .RESETN_I(RESETN_I), .WR_I(WR_I), .RD_I(RD_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I),
  .RDATA_O(RDATA_O), .FLASH_ERASE_O(FLASH_ERASE_O), .FLASH_PROG_O(FLASH_PROG_O), .STALL_O(STALL_O),
  .DONE_FLAG_O(DONE_FLAG_O));
